/* core/bcm_regs.svh */
`ifndef BCM_REGS_SVH
`define BCM_REGS_SVH
// Summary of operation
// - XOR variant sets carry to carry XOR selected operand bit.
// - Inverted XOR sets carry to carry XOR complement of operand bit.
// - Bit load copies the selected operand bit into carry.
// - Inverted bit load writes complement of selected bit into carry.
// - Bit store writes carry into the selected operand bit.
// - Inverted bit store writes complement of carry into selected bit.
// - Inverted variants take bit index only from the literal field.
// - Register form: opcode 15..8, invert flag 7, literal index 6..4, register 3..0.
// - Indirect form: two words, pointer then index in 7..4, low nibble 0.
// - Literal three-bit field picks one of eight operand bits.
// - Set, clear, invert, test also accept register-held bit index.

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define BCM_OPC_HI       15
`define BCM_OPC_LO       8
`define BCM_HI_NIB_HI    7
`define BCM_HI_NIB_LO    4
`define BCM_LO_NIB_HI    3
`define BCM_LO_NIB_LO    0
`define BCM_IDX_MSB      6
`define BCM_INV_BIT      7

// ---------------------------------------------------------------
// Operation codes (byte 15..8)
// ---------------------------------------------------------------
`define BCM_OPC_XOR      8'h75
`define BCM_OPC_LD       8'h77
`define BCM_OPC_ST       8'h67
`define BCM_OPC_SET_R    8'h60
`define BCM_OPC_NOT_R    8'h61
`define BCM_OPC_CLR_R    8'h62
`define BCM_OPC_TST_R    8'h63
`define BCM_OPC_SET_I    8'h70
`define BCM_OPC_NOT_I    8'h71
`define BCM_OPC_CLR_I    8'h72
`define BCM_OPC_TST_I    8'h73
`define BCM_OPC_IND_A    8'h7c
`define BCM_OPC_IND_B    8'h7d
`define BCM_OPC_ABS_A    8'h7e
`define BCM_OPC_ABS_B    8'h7f
`define BCM_ZERO_NIB     4'h0
`define BCM_CARRY_RST    1'b0
`endif

/* core/bcm_pkg.sv */
package bcm_pkg;
  typedef enum logic [3:0] {
    BCM_NONE  = 4'h0,
    BCM_XOR   = 4'h1,
    BCM_LD    = 4'h2,
    BCM_ST    = 4'h3,
    BCM_SET   = 4'h4,
    BCM_CLR   = 4'h5,
    BCM_NOT   = 4'h6,
    BCM_TST   = 4'h7
  } bcm_op_type;

  typedef enum logic [1:0] {
    BCM_FORM_REG = 2'h0,
    BCM_FORM_IND = 2'h1,
    BCM_FORM_ABS = 2'h2
  } bcm_form_type;
endpackage : bcm_pkg

/* core/bcm_bit_unit.sv */
`include "bcm_regs.svh"
module bcm_bit_unit
  import bcm_pkg::*;
(
  input  wire logic [7:0] operand,
  input  wire logic [2:0] bit_index,
  input  wire logic       invert,
  input  wire bcm_op_type op,
  input  wire logic       carry_in,
  output logic            carry_out,
  output logic            carry_we,
  output logic            zero_out,
  output logic            zero_we,
  output logic [7:0]      result,
  output logic            result_we
);
  logic sel_bit;
  logic [7:0] mask;

  assign sel_bit = operand[bit_index] ^ invert;
  assign mask    = 8'h01 << bit_index;

  always_comb
  begin
    carry_out = carry_in;
    carry_we  = 1'b0;
    zero_out  = 1'b0;
    zero_we   = 1'b0;
    result    = operand;
    result_we = 1'b0;
    case (op)
      BCM_XOR:
      begin
        carry_out = carry_in ^ sel_bit;
        carry_we  = 1'b1;
      end
      BCM_LD:
      begin
        carry_out = sel_bit;
        carry_we  = 1'b1;
      end
      BCM_ST:
      begin
        // Only the masked bit moves; the rest pass through.
        result    = ((carry_in ^ invert) ? (operand | mask)
                                         : (operand & ~mask));
        result_we = 1'b1;
      end
      BCM_SET:
      begin
        result    = operand | mask;
        result_we = 1'b1;
      end
      BCM_CLR:
      begin
        result    = operand & ~mask;
        result_we = 1'b1;
      end
      BCM_NOT:
      begin
        result    = operand ^ mask;
        result_we = 1'b1;
      end
      BCM_TST:
      begin
        zero_out = ~operand[bit_index];
        zero_we  = 1'b1;
      end
      default:
      begin
        carry_out = carry_in;
      end
    endcase
  end
endmodule : bcm_bit_unit

/* core/bcm_decoder.sv */
`include "bcm_regs.svh"
module bcm_decoder
  import bcm_pkg::*;
(
  input  wire logic [15:0] word,
  output bcm_op_type       op,
  output logic             invert,
  output logic             reg_index,
  output logic             valid
);
  logic [7:0] opc;
  assign opc = word[`BCM_OPC_HI:`BCM_OPC_LO];

  always_comb
  begin
    op        = BCM_NONE;
    invert    = word[`BCM_INV_BIT];
    reg_index = 1'b0;
    valid     = 1'b1;
    if (opc == `BCM_OPC_XOR)
      op = BCM_XOR;
    else if (opc == `BCM_OPC_LD)
      op = BCM_LD;
    else if (opc == `BCM_OPC_ST)
      op = BCM_ST;
    else if (opc == `BCM_OPC_SET_R || opc == `BCM_OPC_SET_I)
      op = BCM_SET;
    else if (opc == `BCM_OPC_NOT_R || opc == `BCM_OPC_NOT_I)
      op = BCM_NOT;
    else if (opc == `BCM_OPC_CLR_R || opc == `BCM_OPC_CLR_I)
      op = BCM_CLR;
    else if (opc == `BCM_OPC_TST_R || opc == `BCM_OPC_TST_I)
      op = BCM_TST;
    else
      valid = 1'b0;
    // Register-held index forms exist only for set/clear/invert/test.
    if (opc[7:4] == 4'h6 && opc[3:2] == 2'b00)
    begin
      reg_index = 1'b1;
      invert    = 1'b0;
    end
    // Inverted variants never take a register index.
    if (op == BCM_SET || op == BCM_CLR || op == BCM_NOT || op == BCM_TST)
      invert = 1'b0;
  end
endmodule : bcm_decoder

/* core/bcm_core.sv */
`include "bcm_regs.svh"
module bcm_core
  import bcm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        insn_valid,
  input  wire logic [15:0] insn_word,
  output logic             insn_ready,
  output logic [3:0]       reg_rd_sel,
  input  wire logic [7:0]  reg_rd_data,
  output logic [3:0]       idx_rd_sel,
  input  wire logic [7:0]  idx_rd_data,
  output logic             reg_we,
  output logic [3:0]       reg_wr_sel,
  output logic [7:0]       reg_wr_data,
  output logic [3:0]       ptr_sel,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic [7:0]       mem_addr,
  output logic [7:0]       mem_wr_data,
  input  wire logic [7:0]  mem_rd_data,
  input  wire logic [7:0]  ptr_data,
  input  wire logic        carry_in,
  output logic             carry_q,
  output logic             carry_we_q,
  output logic             zero_q,
  output logic             zero_we_q,
  output logic             insn_error_q
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_WORD2 = 5'b00010,
    ST_READ  = 5'b00100,
    ST_EXEC  = 5'b01000,
    ST_WRITE = 5'b10000
  } bcm_state_type;

  bcm_state_type state_q;
  logic [15:0]  first_q;
  logic [15:0]  second_q;
  logic [7:0]   addr_q;
  logic [7:0]   data_q;
  bcm_form_type form_q;
  logic         memop_q;
  logic [7:0]   wdata_q;
  logic         mwr_q;
  logic         mrd_q;

  bcm_op_type  op;
  logic        invert;
  logic        reg_index;
  logic        dec_valid;
  logic [15:0] dec_word;
  logic [2:0]  bit_index;
  logic [7:0]  operand;
  logic        c_out;
  logic        c_we;
  logic        z_out;
  logic        z_we;
  logic [7:0]  res;
  logic        res_we;
  logic        two_word;
  logic        nib_ok;

  // Second word carries the opcode for indirect/absolute forms.
  assign dec_word = memop_q ? second_q : first_q;
  assign two_word = insn_word[15:8] == `BCM_OPC_IND_A
                 || insn_word[15:8] == `BCM_OPC_IND_B
                 || insn_word[15:8] == `BCM_OPC_ABS_A
                 || insn_word[15:8] == `BCM_OPC_ABS_B;

  bcm_decoder u_dec (
    .word      (dec_word),
    .op        (op),
    .invert    (invert),
    .reg_index (reg_index),
    .valid     (dec_valid)
  );

  // ---------------------------------------------------------------
  // Bit index selection
  // ---------------------------------------------------------------
  assign idx_rd_sel = dec_word[`BCM_HI_NIB_HI:`BCM_HI_NIB_LO];
  always_comb
  begin
    if (reg_index)
      bit_index = idx_rd_data[2:0];
    else
      bit_index = dec_word[`BCM_IDX_MSB:`BCM_HI_NIB_LO];
  end

  assign reg_rd_sel = first_q[`BCM_LO_NIB_HI:`BCM_LO_NIB_LO];
  assign ptr_sel    = first_q[`BCM_HI_NIB_HI:`BCM_HI_NIB_LO];
  assign operand    = memop_q ? data_q : reg_rd_data;

  // Low nibble of word two must be zero; word one's too, except in the absolute form.
  assign nib_ok = !memop_q
    || (second_q[`BCM_LO_NIB_HI:`BCM_LO_NIB_LO] == `BCM_ZERO_NIB
        && (form_q == BCM_FORM_ABS
            || first_q[`BCM_LO_NIB_HI:`BCM_LO_NIB_LO]
               == `BCM_ZERO_NIB));

  bcm_bit_unit u_bit (
    .operand   (operand),
    .bit_index (bit_index),
    .invert    (invert),
    .op        (op),
    .carry_in  (carry_in),
    .carry_out (c_out),
    .carry_we  (c_we),
    .zero_out  (z_out),
    .zero_we   (z_we),
    .result    (res),
    .result_we (res_we)
  );

  assign insn_ready  = state_q == ST_IDLE || state_q == ST_WORD2;
  assign mem_rd      = mrd_q;
  assign mem_wr      = mwr_q;
  assign mem_addr    = addr_q;
  assign mem_wr_data = wdata_q;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q  <= ST_IDLE;
      first_q  <= 16'h0000;
      second_q <= 16'h0000;
      memop_q  <= 1'b0;
      form_q   <= BCM_FORM_REG;
      addr_q   <= 8'h00;
      data_q   <= 8'h00;
      mrd_q    <= 1'b0;
    end
    else
    begin
      mrd_q <= 1'b0;
      case (state_q)
        ST_IDLE:
          if (insn_valid)
          begin
            first_q <= insn_word;
            memop_q <= two_word;
            form_q  <= insn_word[9] ? BCM_FORM_ABS : BCM_FORM_IND;
            state_q <= two_word ? ST_WORD2 : ST_EXEC;
          end
        ST_WORD2:
          if (insn_valid)
          begin
            second_q <= insn_word;
            addr_q   <= (form_q == BCM_FORM_ABS) ? first_q[7:0] : ptr_data;
            mrd_q    <= 1'b1;
            state_q  <= ST_READ;
          end
        ST_READ:
        begin
          data_q  <= mem_rd_data;
          state_q <= ST_EXEC;
        end
        ST_EXEC:
          state_q <= (memop_q && res_we && dec_valid && nib_ok)
                     ? ST_WRITE : ST_IDLE;
        ST_WRITE:
          state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Results
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      carry_q      <= `BCM_CARRY_RST;
      carry_we_q   <= 1'b0;
      zero_q       <= 1'b0;
      zero_we_q    <= 1'b0;
      reg_we       <= 1'b0;
      reg_wr_sel   <= 4'h0;
      reg_wr_data  <= 8'h00;
      wdata_q      <= 8'h00;
      mwr_q        <= 1'b0;
      insn_error_q <= 1'b0;
    end
    else
    begin
      carry_we_q   <= 1'b0;
      zero_we_q    <= 1'b0;
      reg_we       <= 1'b0;
      mwr_q        <= 1'b0;
      insn_error_q <= 1'b0;
      if (state_q == ST_EXEC)
      begin
        if (!dec_valid || !nib_ok)
          insn_error_q <= 1'b1;
        else
        begin
          carry_q    <= c_out;
          carry_we_q <= c_we;
          zero_q     <= z_out;
          zero_we_q  <= z_we;
          if (res_we && !memop_q)
          begin
            reg_we      <= 1'b1;
            reg_wr_sel  <= reg_rd_sel;
            reg_wr_data <= res;
          end
          if (res_we && memop_q)
          begin
            wdata_q <= res;
            mwr_q   <= 1'b1;
          end
        end
      end
    end
  end
endmodule : bcm_core

/* dv/bcm_core_chk.sv */
module bcm_core_chk (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        insn_valid,
  input wire logic [15:0] insn_word,
  input wire logic        insn_ready,
  input wire logic [7:0]  reg_rd_data,
  input wire logic [7:0]  idx_rd_data,
  input wire logic        reg_we,
  input wire logic [3:0]  reg_wr_sel,
  input wire logic [7:0]  reg_wr_data,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic [7:0]  mem_wr_data,
  input wire logic [7:0]  mem_rd_data,
  input wire logic        carry_in,
  input wire logic        carry_q,
  input wire logic        carry_we_q,
  input wire logic        zero_q,
  input wire logic        zero_we_q
);
  logic [15:0] w_q;
  logic [7:0]  rd_q, ix_q, md_q;
  logic        cin_q, two_q;
  wire         tk = insn_valid && insn_ready;
  wire  [7:0]  m  = 8'h01 << w_q[6:4];
  wire         bt = |(rd_q & m);
  wire  [7:0]  nv = {8{cin_q ^ w_q[7]}} & m;
  // ---------------------------------------------
  // Helper state
  // ---------------------------------------------
  always_ff @(posedge clk)
  begin
    rd_q  <= reg_rd_data;
    ix_q  <= idx_rd_data;
    cin_q <= carry_in;
    if (mem_rd)
      md_q <= mem_rd_data;
    if (tk)
      w_q <= insn_word;
  end
  // Word two of a memory form reuses the register opcodes, so track it.
  always_ff @(posedge clk)
    if (reset)
      two_q <= 1'b0;
    else if (tk)
      two_q <= !two_q && insn_word[15:10] == 6'h1f;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_xor;
    tk && !two_q && insn_word[15:8] == 8'h75 |-> ##2
      carry_we_q && carry_q == (cin_q ^ bt ^ w_q[7]);
  endproperty
  a_xor: assert property (p_xor)
    else $error("xor carry wrong");
  property p_ld;
    tk && !two_q && insn_word[15:8] == 8'h77 |-> ##2
      carry_we_q && carry_q == (bt ^ w_q[7]);
  endproperty
  a_ld: assert property (p_ld)
    else $error("load carry wrong");
  property p_st;
    tk && !two_q && insn_word[15:8] == 8'h67 |-> ##2 reg_we &&
      reg_wr_sel == w_q[3:0] && reg_wr_data == ((rd_q & ~m) | nv);
  endproperty
  a_st: assert property (p_st)
    else $error("store data wrong");
  property p_tst;
    tk && !two_q && insn_word[15:8] == 8'h63 |-> ##2
      zero_we_q && zero_q == !rd_q[ix_q[2:0]];
  endproperty
  a_tst: assert property (p_tst)
    else $error("test flag wrong");
  property p_mwr;
    mem_wr |-> mem_wr_data == ((md_q & ~m) | nv);
  endproperty
  a_mwr: assert property (p_mwr)
    else $error("memory store wrong");
  property p_mrd;
    tk && two_q |=> mem_rd ##1 !mem_rd;
  endproperty
  a_mrd: assert property (p_mrd)
    else $error("memory read missing");
  property p_rst;
    $fell(reset) |-> insn_ready && !carry_we_q;
  endproperty
  a_rst: assert property (p_rst) else $error("not idle after reset");
  property p_cwe;
    carry_we_q |=> !carry_we_q;
  endproperty
  a_cwe: assert property (p_cwe) else $error("carry strobe too long");
  c_two: cover property (tk && two_q);
  c_tst: cover property (zero_we_q);
  c_mwr: cover property (mem_wr);
endmodule : bcm_core_chk

bind bcm_core bcm_core_chk u_chk (.clk, .reset, .insn_valid, .insn_word,
  .insn_ready, .reg_rd_data, .idx_rd_data, .reg_we, .reg_wr_sel,
  .reg_wr_data, .mem_rd, .mem_wr, .mem_wr_data, .mem_rd_data, .carry_in,
  .carry_q, .carry_we_q, .zero_q, .zero_we_q);

/* dv/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, reset, insn_valid, carry_in, insn_ready, reg_we;
  logic        mem_rd, mem_wr, carry_q, carry_we_q, zero_q, zero_we_q;
  logic        insn_error_q, cs, cv, zs, zv, es;
  logic [15:0] insn_word;
  logic [3:0]  reg_rd_sel, idx_rd_sel, reg_wr_sel, ptr_sel;
  logic [7:0]  reg_rd_data, idx_rd_data, ptr_data, mem_rd_data;
  logic [7:0]  reg_wr_data, mem_addr, mem_wr_data;
  logic [7:0]  rf [16];
  logic [7:0]  mem [256];
  int          errors, samples_checked;
  bcm_core u_dut (.clk(clk), .reset(reset), .insn_valid(insn_valid),
    .insn_word(insn_word), .insn_ready(insn_ready),
    .reg_rd_sel(reg_rd_sel), .reg_rd_data(reg_rd_data),
    .idx_rd_sel(idx_rd_sel), .idx_rd_data(idx_rd_data), .reg_we(reg_we),
    .reg_wr_sel(reg_wr_sel), .reg_wr_data(reg_wr_data), .ptr_sel(ptr_sel),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wr_data(mem_wr_data), .mem_rd_data(mem_rd_data),
    .ptr_data(ptr_data), .carry_in(carry_in), .carry_q(carry_q),
    .carry_we_q(carry_we_q), .zero_q(zero_q), .zero_we_q(zero_we_q),
    .insn_error_q(insn_error_q));
  // ---------------------------------------------
  // Register file, memory and flag capture
  // ---------------------------------------------
  assign reg_rd_data = rf[reg_rd_sel];
  assign idx_rd_data = rf[idx_rd_sel];
  assign ptr_data    = rf[ptr_sel];
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // The core captures read data at the edge that ends its read strobe.
  assign mem_rd_data = mem_rd ? mem[mem_addr] : 8'h00;
  always @(posedge clk)
  begin
    if (mem_wr) mem[mem_addr] <= mem_wr_data;
    if (reg_we) rf[reg_wr_sel] <= reg_wr_data;
    if (carry_we_q) {cs, cv} <= {1'b1, carry_q};
    if (zero_we_q) {zs, zv} <= {1'b1, zero_q};
    if (insn_error_q) es <= 1'b1;
  end
  // ---------------------------------------------
  // Tasks
  // ---------------------------------------------
  task chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Ready is read at the falling edge so the take edge is never ambiguous.
  task put(input logic [15:0] w);
    logic r;
    insn_valid <= 1'b1;
    insn_word  <= w;
    do
    begin
      @(negedge clk) r = insn_ready;
      @(posedge clk);
    end while (!r);
  endtask : put
  task run(input logic [15:0] w1, w2, input logic two, cin);
    {cs, zs, es} <= 3'b000;
    carry_in <= cin;
    put(w1);
    if (two) put(w2);
    insn_valid <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : run
  task t_reg;
    logic [7:0] op, v, e;
    logic [2:0] ix;
    logic [3:0] r;
    logic       inv, c, b;
    for (int i = 0; i < 12; i++)
    begin
      op  = (i < 4) ? 8'h75 : (i < 8) ? 8'h77 : 8'h67;
      ix  = 3'(i * 3);
      r   = 4'(i);
      inv = i[0];
      c   = i[1];
      v   = rf[r];
      b   = v[ix] ^ inv;
      run({op, inv, ix, r}, 16'h0000, 1'b0, c);
      e     = v;
      e[ix] = c ^ inv;
      if (op == 8'h67)
        chk(rf[r], e);
      else
      begin
        b = (op == 8'h75 && c) ^ b;
        chk({cs, cv}, {1'b1, b});
      end
    end
    $display("t_reg done");
  endtask : t_reg
  task t_idx;
    logic [7:0] v;
    logic [2:0] ix;
    v  = rf[5];
    ix = rf[2][2:0];
    run(16'h6325, 16'h0000, 1'b0, 1'b0);
    chk({zs, zv}, {1'b1, ~v[ix]});
    run(16'h6025, 16'h0000, 1'b0, 1'b0);
    chk(rf[5], v | (8'h01 << ix));
    v = rf[5];
    run(16'h6125, 16'h0000, 1'b0, 1'b0);
    chk(rf[5], v ^ (8'h01 << ix));
    v = rf[5];
    run(16'h7235, 16'h0000, 1'b0, 1'b0);
    chk(rf[5], v & 8'hf7);
    $display("t_idx done");
  endtask : t_idx
  task t_mem;
    run(16'h7e40, 16'h67d0, 1'b1, 1'b1);
    chk(mem[8'h40], 8'hdf);
    run(16'h7c30, 16'h7700, 1'b1, 1'b0);
    chk({cs, cv}, 8'h03);
    run(16'h7c30, 16'h7705, 1'b1, 1'b0);
    chk({es, cs}, 8'h02);
    $display("t_mem done");
  endtask : t_mem
  task test_done;
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  initial
  begin
    reset = 1'b1;
    insn_valid = 1'b0;
    insn_word = 16'h0000;
    carry_in = 1'b0;
    errors = 0;
    samples_checked = 0;
    for (int k = 0; k < 16; k++) rf[k] = {4'(k), ~4'(k)};
    rf[3] = 8'h40;
    for (int k = 0; k < 256; k++) mem[k] = 8'hff;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reg;
    t_idx;
    t_mem;
    test_done;
  end
  // About twenty instructions of nine or ten cycles each fit well inside this.
  initial
  begin
    repeat (3000) @(posedge clk);
    errors++;
    test_done;
  end
endmodule : testbench
